// ### src/dshs_pkg.sv
// Shared constants and types for the host serial and handshake block.
package dshs_pkg;
  // Register byte addresses on the slave port, one aligned word each.
  localparam logic [4:0] ADDR_CTRL    = 5'h00;
  localparam logic [4:0] ADDR_STATUS  = 5'h04;
  localparam logic [4:0] ADDR_RXDATA  = 5'h08;
  localparam logic [4:0] ADDR_DATA_TX = 5'h0C;
  localparam logic [4:0] ADDR_RESP_TX = 5'h10;
  localparam logic [4:0] ADDR_GPIO    = 5'h14;
  localparam logic [4:0] ADDR_BAUD    = 5'h18;
  // Control register field positions.
  localparam int CTL_READY   = 0;
  localparam int CTL_CONNECT = 1;
  localparam int CTL_DUPLEX  = 2;
  localparam int CTL_LINK    = 3;
  localparam int CTL_CMDMODE = 4;
  localparam int CTL_RING    = 5;
  localparam int CTL_SLAVE   = 6;
  localparam int CTL_OFFHOOK = 7;
  localparam int CTL_DTRB    = 8;
  localparam int CTL_FLOW    = 10;
  localparam int CTL_W       = 12;
  // Status register field positions.
  localparam int ST_RXVAL = 0;
  localparam int ST_RXCMD = 1;
  localparam int ST_OVR   = 2;
  localparam int ST_FERR  = 3;
  localparam int ST_DROP  = 4;
  // Reset values.
  localparam logic [11:0] CTRL_RST  = 12'h000;
  localparam logic [15:0] BAUD_RST  = 16'h0364;
  localparam logic [3:0]  GPIO_OE_N_RST = 4'hF;
  // Times as printed and the cycle counts derived from them.
  localparam int CLK_PERIOD_NS   = 10;
  localparam int NS_PER_MS       = 1000000;
  localparam int LED_PHASE_MS    = 50;
  localparam int RI_PERIOD_MS    = 1000;
  localparam int RI_PULSE_MS     = 100;
  localparam int LED_PHASE_CYC = LED_PHASE_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int RI_PERIOD_CYC = RI_PERIOD_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int RI_PULSE_CYC  = RI_PULSE_MS * NS_PER_MS / CLK_PERIOD_NS;
  // How a drop of the terminal ready line is handled.
  typedef enum logic [1:0] {
    DTRB_IGNORE = 2'b00,
    DTRB_CMD    = 2'b01,
    DTRB_HANGUP = 2'b10,
    DTRB_RESET  = 2'b11
  } dshs_dtrb_e;
  // Serial engine states shared by both directions.
  typedef enum logic [1:0] {
    SER_IDLE  = 2'b00,
    SER_START = 2'b01,
    SER_DATA  = 2'b10,
    SER_STOP  = 2'b11
  } dshs_ser_e;
endpackage

// ### src/dshs_top.sv
// Host serial data and modem handshake block with its register slave.
`timescale 1ns/1ps
// How it works
// - Responses and line data share RXD; responses first.
// - RXD rests at mark when idle.
// - TXD carries both data and commands.
// - RI low during each ring ON segment.
// - No off-hook while RI is active.
// - Slave role pulses RI once per second.
// - DSR follows local readiness only.
// - CTS low when TXD characters will be taken.
// - DCD low while a connection is up.
// - DTR low permits and holds a connection.
// - DTR high disconnects per configured settings.
// - Duplex LED low in full duplex.
// - Activity LED blinks 50 ms phases.
// - Link LED low on good link.
// - Four general pins, each input or output.
// - No new line data starts on RXD while RTS high.
module dshs_top #(
  parameter int GPIO_N        = 4,
  parameter int LED_PHASE_CYC = dshs_pkg::LED_PHASE_CYC,
  parameter int RI_PERIOD_CYC = dshs_pkg::RI_PERIOD_CYC,
  parameter int RI_PULSE_CYC  = dshs_pkg::RI_PULSE_CYC
) (
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic [4:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              txd,
  input  wire logic              dtr_n,
  input  wire logic              rts_n,
  output logic                   rxd,
  output logic                   ri_n,
  output logic                   dsr_n,
  output logic                   cts_n,
  output logic                   dcd_n,
  output logic                   duplex_led_n,
  output logic                   activity_led_n,
  output logic                   link_good_led_n,
  input  wire logic [GPIO_N-1:0] gpio_in,
  output logic [GPIO_N-1:0]      gpio_out,
  output logic [GPIO_N-1:0]      gpio_oe_n
);
  // Software state.
  logic [11:0]       ctrl_r;     // Control fields.
  logic [15:0]       baud_r;     // Clock cycles per serial bit.
  logic [GPIO_N-1:0] gpioOut_r;  // Levels driven on output pins.
  logic [GPIO_N-1:0] gpioOeN_r;  // Low marks a pin as output.
  // Holding bytes towards the host.
  logic [7:0]        dataByte_r; // Line data waiting for RXD.
  logic              dataPend_r;
  logic [7:0]        respByte_r; // Response waiting for RXD.
  logic              respPend_r;
  // Byte taken from the host.
  logic [7:0]        rxByte_r;
  logic              rxValid_r;
  logic              rxCmd_r;    // Taken in command mode or while not connected.
  logic              rxOvr_r;    // Sticky: a byte was lost.
  logic              fErr_r;     // Sticky: bad stop bit seen.
  logic              dtrDrop_r;  // Sticky: DTR went off, unless the DTR setting is ignore.
  // Call state.
  logic              offHook_r;
  logic              connected_r;
  // Pin synchronisers.
  logic              txdS1_r, txdS2_r;
  logic              dtrS1_r, dtrS2_r, dtrPrev_r;
  logic              rtsS1_r, rtsS2_r;
  logic [GPIO_N-1:0] gpS1_r, gpS2_r;
  // Timers.
  logic [31:0]       riCnt_r;
  logic [31:0]       ledCnt_r;
  logic              ledPhase_r;
  // Bus.
  logic              waitReq_r;
  logic [31:0]       rdData_r;

  // Decoded control fields and handshake line levels.
  logic ready, dtrOn, rtsOn, riActive, active;
  dshs_pkg::dshs_dtrb_e dtrb;
  logic [1:0] flow;
  assign ready    = ctrl_r[dshs_pkg::CTL_READY];
  assign dtrb     = dshs_pkg::dshs_dtrb_e'(ctrl_r[dshs_pkg::CTL_DTRB +: 2]);
  assign flow     = ctrl_r[dshs_pkg::CTL_FLOW +: 2];
  assign dtrOn    = ~dtrS2_r;
  assign rtsOn    = ~rtsS2_r;
  assign riActive = ~ri_n;

  // Serial engines.
  logic txBusy, txStart, rxBusy, rxDone, rxFerr;
  logic [7:0] txData, rxData;

  dshs_uart_tx #(.DIV_W(16)) uTx (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .start   (txStart),
    .data    (txData),
    .div     (baud_r),
    .busy    (txBusy),
    .txd     (rxd)
  );

  dshs_uart_rx #(.DIV_W(16)) uRx (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .rxd      (txdS2_r),
    .div      (baud_r),
    .busy     (rxBusy),
    .done     (rxDone),
    .frameErr (rxFerr),
    .data     (rxData)
  );

  // Responses win the line; line data also waits for RTS.
  logic selResp;
  assign selResp = respPend_r;
  assign txStart = ~txBusy &
                   (respPend_r | (dataPend_r & rtsOn));
  assign txData  = selResp ? respByte_r : dataByte_r;

  // Bus request decode. A write into a full holder is stalled with
  // waitrequest so the producer feels the back-pressure.
  logic busReq, wrBlock, accept, wrAcc, rdAcc;
  logic [31:0] rdNxt;
  assign busReq  = (avs_read | avs_write) & waitReq_r;
  assign wrBlock = avs_write &
    ((avs_address == dshs_pkg::ADDR_DATA_TX & dataPend_r) |
     (avs_address == dshs_pkg::ADDR_RESP_TX & respPend_r));
  assign accept  = busReq & ~wrBlock;
  assign wrAcc   = accept & avs_write;
  assign rdAcc   = accept & avs_read;

  // Read mux; unmapped addresses read as zero.
  always_comb begin
    rdNxt = 32'h0000_0000;
    if (avs_address == dshs_pkg::ADDR_CTRL) begin
      rdNxt[11:0] = ctrl_r;
    end else if (avs_address == dshs_pkg::ADDR_STATUS) begin
      rdNxt[dshs_pkg::ST_RXVAL] = rxValid_r;
      rdNxt[dshs_pkg::ST_RXCMD] = rxCmd_r;
      rdNxt[dshs_pkg::ST_OVR]   = rxOvr_r;
      rdNxt[dshs_pkg::ST_FERR]  = fErr_r;
      rdNxt[dshs_pkg::ST_DROP]  = dtrDrop_r;
      rdNxt[11:5] = {dataPend_r, respPend_r, txBusy, rtsOn, dtrOn,
                     connected_r, offHook_r};
    end else if (avs_address == dshs_pkg::ADDR_RXDATA) begin
      rdNxt[7:0] = rxByte_r;
    end else if (avs_address == dshs_pkg::ADDR_GPIO) begin
      rdNxt[11:0] = {gpS2_r, ~gpioOeN_r, gpioOut_r};
    end else if (avs_address == dshs_pkg::ADDR_BAUD) begin
      rdNxt[15:0] = baud_r;
    end
  end

  // Waitrequest drops for exactly one cycle per accepted access, so the
  // side effects of an access happen once even though the master holds.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      waitReq_r <= 1'b1;
      rdData_r  <= 32'h0000_0000;
    end else begin
      waitReq_r <= ~accept;
      if (rdAcc) begin
        rdData_r <= rdNxt;
      end
    end
  end
  assign avs_waitrequest = waitReq_r;
  assign avs_readdata    = rdData_r;

  // Software-written configuration.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ctrl_r    <= dshs_pkg::CTRL_RST;
      baud_r    <= dshs_pkg::BAUD_RST;
      gpioOut_r <= '0;
      gpioOeN_r <= dshs_pkg::GPIO_OE_N_RST;
    end else if (wrAcc) begin
      if (avs_address == dshs_pkg::ADDR_CTRL) begin
        ctrl_r <= avs_writedata[11:0];
      end else if (avs_address == dshs_pkg::ADDR_GPIO) begin
        gpioOut_r <= avs_writedata[3:0];
        gpioOeN_r <= ~avs_writedata[7:4];
      end else if (avs_address == dshs_pkg::ADDR_BAUD) begin
        baud_r <= avs_writedata[15:0];
      end
    end
  end
  assign gpio_out  = gpioOut_r;
  assign gpio_oe_n = gpioOeN_r;

  // Outgoing holders; a write is only taken once its holder is empty.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      dataByte_r <= 8'h00;
      dataPend_r <= 1'b0;
      respByte_r <= 8'h00;
      respPend_r <= 1'b0;
    end else begin
      if (wrAcc && avs_address == dshs_pkg::ADDR_DATA_TX) begin
        dataByte_r <= avs_writedata[7:0];
        dataPend_r <= 1'b1;
      end else if (txStart && !selResp) begin
        dataPend_r <= 1'b0;
      end
      if (wrAcc && avs_address == dshs_pkg::ADDR_RESP_TX) begin
        respByte_r <= avs_writedata[7:0];
        respPend_r <= 1'b1;
      end else if (txStart && selResp) begin
        respPend_r <= 1'b0;
      end
    end
  end

  // Pin synchronisers; only the second stage, and the DTR edge register behind it, is read by logic.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      txdS1_r   <= 1'b1;
      txdS2_r   <= 1'b1;
      dtrS1_r   <= 1'b1;
      dtrS2_r   <= 1'b1;
      dtrPrev_r <= 1'b1;
      rtsS1_r   <= 1'b1;
      rtsS2_r   <= 1'b1;
    end else begin
      txdS1_r   <= txd;
      txdS2_r   <= txdS1_r;
      dtrS1_r   <= dtr_n;
      dtrS2_r   <= dtrS1_r;
      dtrPrev_r <= dtrS2_r;
      rtsS1_r   <= rts_n;
      rtsS2_r   <= rtsS1_r;
    end
  end

  // General pin inputs, one synchroniser per pin.
  for (genvar g = 0; g < GPIO_N; g++) begin : gGpio
    always_ff @(posedge sys_clk) begin
      if (!resetn) begin
        gpS1_r[g] <= 1'b0;
        gpS2_r[g] <= 1'b0;
      end else begin
        gpS1_r[g] <= gpio_in[g];
        gpS2_r[g] <= gpS1_r[g];
      end
    end
  end

  // Received byte store. A new byte wins over a same-cycle read, and a
  // byte landing on an unread one flags an overrun.
  logic rxPop, stClr, dtrDropEvt, dropHang;
  assign rxPop = rdAcc & (avs_address == dshs_pkg::ADDR_RXDATA);
  assign stClr = wrAcc & (avs_address == dshs_pkg::ADDR_STATUS);
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rxByte_r  <= 8'h00;
      rxValid_r <= 1'b0;
      rxCmd_r   <= 1'b0;
      rxOvr_r   <= 1'b0;
      fErr_r    <= 1'b0;
    end else begin
      if (rxDone) begin
        rxByte_r  <= rxData;
        rxValid_r <= 1'b1;
        rxCmd_r   <= ctrl_r[dshs_pkg::CTL_CMDMODE] | ~connected_r;
      end else if (rxPop) begin
        rxValid_r <= 1'b0;
      end
      if (rxDone && rxValid_r && !rxPop) begin
        rxOvr_r <= 1'b1;
      end else if (stClr && avs_writedata[dshs_pkg::ST_OVR]) begin
        rxOvr_r <= 1'b0;
      end
      if (rxFerr) begin
        fErr_r <= 1'b1;
      end else if (stClr && avs_writedata[dshs_pkg::ST_FERR]) begin
        fErr_r <= 1'b0;
      end
    end
  end

  // A DTR drop hangs up for the hang-up settings, and also for the
  // command setting when flow control is off, since then nothing else
  // can hold the host back.
  assign dtrDropEvt = dtrS2_r & ~dtrPrev_r;
  assign dropHang = dtrDropEvt &
    (dtrb == dshs_pkg::DTRB_HANGUP || dtrb == dshs_pkg::DTRB_RESET ||
     (dtrb == dshs_pkg::DTRB_CMD && flow == 2'b00));
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      dtrDrop_r <= 1'b0;
    end else if (dtrDropEvt && dtrb != dshs_pkg::DTRB_IGNORE) begin
      dtrDrop_r <= 1'b1;
    end else if (stClr && avs_writedata[dshs_pkg::ST_DROP]) begin
      dtrDrop_r <= 1'b0;
    end
  end

  // Hook state: going off-hook needs DTR permission and no active ring.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      offHook_r <= 1'b0;
    end else if (dropHang || !ctrl_r[dshs_pkg::CTL_OFFHOOK]) begin
      offHook_r <= 1'b0;
    end else if (dtrOn && !riActive) begin
      offHook_r <= 1'b1;
    end
  end

  // Connection comes up only with DTR on and ready set, and holds while the line is taken and connect stays set, until a hang-up DTR drop.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      connected_r <= 1'b0;
    end else if (dropHang || !offHook_r ||
                 !ctrl_r[dshs_pkg::CTL_CONNECT]) begin
      connected_r <= 1'b0;
    end else if (dtrOn && ready) begin
      connected_r <= 1'b1;
    end
  end

  // Ring indication, with a short strobe each second in the slave role.
  logic riNxt;
  assign riNxt = ctrl_r[dshs_pkg::CTL_RING] |
    (ctrl_r[dshs_pkg::CTL_SLAVE] & (riCnt_r < RI_PULSE_CYC));
  always_ff @(posedge sys_clk) begin
    if (!resetn || !ctrl_r[dshs_pkg::CTL_SLAVE]) begin
      riCnt_r <= 32'h0000_0000;
    end else if (riCnt_r == 32'(RI_PERIOD_CYC - 1)) begin
      riCnt_r <= 32'h0000_0000;
    end else begin
      riCnt_r <= riCnt_r + 32'h0000_0001;
    end
  end

  // Activity blink timer, restarted with a lit phase on each burst.
  assign active = txBusy | rxBusy;
  always_ff @(posedge sys_clk) begin
    if (!resetn || !active) begin
      ledCnt_r   <= 32'h0000_0000;
      ledPhase_r <= 1'b0;
    end else if (ledCnt_r == 32'(LED_PHASE_CYC - 1)) begin
      ledCnt_r   <= 32'h0000_0000;
      ledPhase_r <= ~ledPhase_r;
    end else begin
      ledCnt_r <= ledCnt_r + 32'h0000_0001;
    end
  end

  // Handshake and lamp outputs, all registered.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ri_n            <= 1'b1;
      dsr_n           <= 1'b1;
      cts_n           <= 1'b1;
      dcd_n           <= 1'b1;
      duplex_led_n    <= 1'b1;
      activity_led_n  <= 1'b1;
      link_good_led_n <= 1'b1;
    end else begin
      ri_n            <= ~riNxt;
      dsr_n           <= ~ready;
      cts_n           <= ~(ready & ~rxValid_r);
      dcd_n           <= ~connected_r;
      duplex_led_n    <= ~(ready & ctrl_r[dshs_pkg::CTL_DUPLEX]);
      activity_led_n  <= ~(ready & active & ~ledPhase_r);
      link_good_led_n <= ~(ready & ctrl_r[dshs_pkg::CTL_LINK]);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  a_resp_first: assert property (
    txStart && respPend_r && dataPend_r |=> !respPend_r && dataPend_r)
    else $error("line data sent ahead of a pending response");
  a_rts_hold: assert property (
    txStart && !respPend_r |-> rtsOn && dataPend_r)
    else $error("line data started while RTS was off");
  a_ring_low: assert property (
    ctrl_r[dshs_pkg::CTL_RING] |=> !ri_n)
    else $error("RI not low during a ring segment");
  a_hook_ring: assert property (
    $rose(offHook_r) |-> !$past(riActive))
    else $error("went off-hook while RI was active");
  a_dsr_local: assert property (
    ##1 dsr_n == !$past(ready))
    else $error("DSR does not follow local readiness");
  a_cts_full: assert property (
    rxValid_r |=> cts_n)
    else $error("CTS on while the receive holder is full");
  a_dcd_conn: assert property (
    $rose(connected_r) |=> !dcd_n ##0 $past(dtrOn, 2))
    else $error("DCD not low after connection");
  a_dtr_hang: assert property (
    dropHang |=> !offHook_r ##1 !connected_r)
    else $error("DTR drop did not disconnect");
  a_wait_pulse: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");

  c_resp_and_data: cover property (txStart && respPend_r && dataPend_r);
  c_rx_byte: cover property (rxDone ##[1:1000] rxPop);
  c_dtr_hangup: cover property (connected_r ##1 dropHang);
  c_blink: cover property ($rose(ledPhase_r));
endmodule

// ### src/dshs_uart_rx.sv
// Character deserialiser for the transmitted-data line from the host.
`timescale 1ns/1ps
module dshs_uart_rx #(
  parameter int DIV_W = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  input  wire logic             rxd,
  input  wire logic [DIV_W-1:0] div,
  output logic                  busy,
  output logic                  done,
  output logic                  frameErr,
  output logic [7:0]            data
);
  dshs_pkg::dshs_ser_e state_r;   // Current framing phase.
  logic [DIV_W-1:0]    baudCnt_r; // Cycles to the next sample.
  logic [2:0]          bitIdx_r;  // Data bit being taken.

  assign busy = (state_r != dshs_pkg::SER_IDLE);

  // Samples mid-bit; a start edge that does not last is taken as noise.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_r   <= dshs_pkg::SER_IDLE;
      baudCnt_r <= '0;
      bitIdx_r  <= 3'h0;
      done      <= 1'b0;
      frameErr  <= 1'b0;
      data      <= 8'h00;
    end else begin
      done     <= 1'b0;
      frameErr <= 1'b0;
      if (state_r == dshs_pkg::SER_IDLE) begin
        if (!rxd) begin
          state_r   <= dshs_pkg::SER_START;
          baudCnt_r <= div >> 1;
        end
      end else if (baudCnt_r != '0) begin
        baudCnt_r <= baudCnt_r - 1'b1;
      end else begin
        baudCnt_r <= div - 1'b1;
        case (state_r)
          dshs_pkg::SER_START: begin
            state_r  <= rxd ? dshs_pkg::SER_IDLE : dshs_pkg::SER_DATA;
            bitIdx_r <= 3'h0;
          end
          dshs_pkg::SER_DATA: begin
            data     <= {rxd, data[7:1]};
            bitIdx_r <= bitIdx_r + 1'b1;
            if (bitIdx_r == 3'h7) begin
              state_r <= dshs_pkg::SER_STOP;
            end
          end
          default: begin
            state_r  <= dshs_pkg::SER_IDLE;
            done     <= rxd;
            frameErr <= ~rxd;
          end
        endcase
      end
    end
  end
endmodule

// ### src/dshs_uart_tx.sv
// Character serialiser that drives the received-data line to the host.
`timescale 1ns/1ps
module dshs_uart_tx #(
  parameter int DIV_W = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  input  wire logic             start,
  input  wire logic [7:0]       data,
  input  wire logic [DIV_W-1:0] div,
  output logic                  busy,
  output logic                  txd
);
  dshs_pkg::dshs_ser_e state_r;   // Current framing phase.
  logic [DIV_W-1:0]    baudCnt_r; // Cycles left in this bit.
  logic [2:0]          bitIdx_r;  // Data bit being sent.
  logic [7:0]          shift_r;   // Character, low bit first.

  assign busy = (state_r != dshs_pkg::SER_IDLE);

  // Walk start, eight data bits and one stop bit; idle holds mark.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_r   <= dshs_pkg::SER_IDLE;
      baudCnt_r <= '0;
      bitIdx_r  <= 3'h0;
      shift_r   <= 8'h00;
      txd       <= 1'b1;
    end else if (state_r == dshs_pkg::SER_IDLE) begin
      txd <= 1'b1;
      if (start) begin
        state_r   <= dshs_pkg::SER_START;
        shift_r   <= data;
        baudCnt_r <= div - 1'b1;
        txd       <= 1'b0;
      end
    end else if (baudCnt_r != '0) begin
      baudCnt_r <= baudCnt_r - 1'b1;
    end else begin
      baudCnt_r <= div - 1'b1;
      case (state_r)
        dshs_pkg::SER_START: begin
          state_r  <= dshs_pkg::SER_DATA;
          bitIdx_r <= 3'h0;
          txd      <= shift_r[0];
        end
        dshs_pkg::SER_DATA: begin
          if (bitIdx_r == 3'h7) begin
            state_r <= dshs_pkg::SER_STOP;
            txd     <= 1'b1;
          end else begin
            bitIdx_r <= bitIdx_r + 1'b1;
            txd      <= shift_r[bitIdx_r + 1'b1];
          end
        end
        default: begin
          state_r <= dshs_pkg::SER_IDLE;
          txd     <= 1'b1;
        end
      endcase
    end
  end

  // The line rests at mark whenever no character is in flight.
  a_idle_mark: assert property (@(posedge sys_clk) disable iff (!resetn)
    (state_r == dshs_pkg::SER_IDLE && $past(state_r) ==
     dshs_pkg::SER_IDLE) |-> txd)
    else $error("serial output not at mark while idle");
endmodule

// ### testbench/dshs_host_model.sv
// Host terminal model: serial sender, serial receiver and handshake lines.
`timescale 1ns/1ps
module dshs_host_model #(
  parameter int BIT_CYC = 16
) (
  input  wire logic sys_clk,
  input  wire logic rxd,
  output logic      txd,
  output logic      dtr_n,
  output logic      rts_n
);
  // The bench moves the handshake lines; they start off, line at mark.
  initial begin
    txd   = 1'b1;
    dtr_n = 1'b1;
    rts_n = 1'b1;
  end
  // Sends one frame, LSB first; the stop bit leaves the line at mark.
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      txd <= f[i];
      repeat (BIT_CYC) @(posedge sys_clk);
    end
  endtask
  // Waits a bounded time for a start bit, then samples near mid-bit.
  task automatic get(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    while (rxd !== 1'b0 && n < 4000) begin
      @(posedge sys_clk);
      n++;
    end
    repeat (BIT_CYC / 2) @(posedge sys_clk);
    ok = (rxd === 1'b0);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge sys_clk);
      b[i] = rxd;
    end
    repeat (BIT_CYC) @(posedge sys_clk);
    ok = ok && (rxd === 1'b1);
  endtask
endmodule

// ### testbench/tb.sv
// Self-checking bench for the host serial and handshake block.
`timescale 1ns/1ps
module tb;
  localparam int BIT_CYC = 16; // Short bit time keeps each frame brief.
  logic        sys_clk, resetn, avs_read, avs_write, avs_waitrequest;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic        txd, dtr_n, rts_n, rxd, ri_n, dsr_n, cts_n, dcd_n;
  logic        duplex_led_n, activity_led_n, link_good_led_n;
  logic [3:0]  gpio_in, gpio_out, gpio_oe_n;
  int          mismatches, compares;
  // Short lamp and ring counts so the blink checks fit in a few cycles.
  dshs_top #(.LED_PHASE_CYC(8), .RI_PERIOD_CYC(20), .RI_PULSE_CYC(4)) dut (
    .sys_clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .txd, .dtr_n, .rts_n, .rxd, .ri_n,
    .dsr_n, .cts_n, .dcd_n, .duplex_led_n, .activity_led_n,
    .link_good_led_n, .gpio_in, .gpio_out, .gpio_oe_n);
  dshs_host_model #(.BIT_CYC(BIT_CYC)) host (.sys_clk, .rxd, .txd, .dtr_n,
    .rts_n);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Counts and reports one comparison.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One bus access; held until waitrequest is seen low, then one idle edge.
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdChk(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(q, e);
  endtask
  // Receives one character at the host and checks byte and framing.
  task automatic getChk(input logic [7:0] e);
    logic [7:0] b;
    logic       ok;
    host.get(b, ok);
    chk({31'h0000_0000, dsr_n}, 32'h0000_0000);
    chk({23'h00_0000, ok, b}, {24'h00_0001, e});
  endtask
  // Counts low cycles of the ring line or the activity lamp over a span.
  task automatic lowCount(input int span, input bit ring, output int n);
    n = 0;
    repeat (span) begin
      @(posedge sys_clk);
      if ((ring ? ri_n : activity_led_n) === 1'b0) n++;
    end
  endtask
  // Pins idle after reset; baud reads back its reset value, a hole reads 0.
  task automatic tReset;
    chk({28'h000_0000, rxd, ri_n, dsr_n, cts_n}, 32'h0000_000F);
    chk({27'h000_0000, dcd_n, duplex_led_n, activity_led_n,
         link_good_led_n, 1'b1}, 32'h0000_001F);
    rdChk(dshs_pkg::ADDR_BAUD, 32'h0000_0364);
    rdChk(5'h1C, 32'h0000_0000);
    wr(dshs_pkg::ADDR_BAUD, 32'h0000_0010);
  endtask
  // Data waits for RTS; a later response still beats pending data.
  task automatic tRxd;
    wr(dshs_pkg::ADDR_CTRL, 32'h0000_0001);
    repeat (2) @(posedge sys_clk);
    chk({31'h0000_0000, dsr_n}, 32'h0000_0000);
    wr(dshs_pkg::ADDR_DATA_TX, 32'h0000_0077);
    repeat (40) @(posedge sys_clk);
    chk({31'h0000_0000, rxd}, 32'h0000_0001);
    wr(dshs_pkg::ADDR_RESP_TX, 32'h0000_0011);
    wr(dshs_pkg::ADDR_RESP_TX, 32'h0000_003C);
    host.rts_n <= 1'b0;
    getChk(8'h11);
    getChk(8'h3C);
    getChk(8'h77);
  endtask
  // A host character arrives, blinks the lamp and closes CTS until read.
  task automatic tTxd;
    int n;
    chk({31'h0000_0000, cts_n}, 32'h0000_0000);
    fork
      host.send(8'h5A);
      begin
        repeat (40) @(posedge sys_clk);
        lowCount(16, 1'b0, n);
      end
    join
    chk(n, 8);
    repeat (8) @(posedge sys_clk);
    chk({31'h0000_0000, cts_n}, 32'h0000_0001);
    rdChk(dshs_pkg::ADDR_RXDATA, 32'h0000_005A);
  endtask
  // Direction and output bits reach the pins; inputs read back.
  task automatic tGpio;
    wr(dshs_pkg::ADDR_GPIO, 32'h0000_00A5);
    rdChk(dshs_pkg::ADDR_GPIO, 32'h0000_03A5);
    chk({24'h00_0000, gpio_oe_n, gpio_out}, 32'h0000_0055);
  endtask
  // Ring blocks the call; after it the call comes up, DTR drop ends it.
  task automatic tCall;
    int n;
    host.dtr_n <= 1'b0;
    wr(dshs_pkg::ADDR_CTRL, 32'h0000_02AF);
    repeat (6) @(posedge sys_clk);
    chk({ri_n, dcd_n, duplex_led_n, link_good_led_n}, 4'h4);
    wr(dshs_pkg::ADDR_CTRL, 32'h0000_028F);
    repeat (6) @(posedge sys_clk);
    chk({ri_n, dcd_n}, 2'h2);
    host.dtr_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk({31'h0000_0000, dcd_n}, 32'h0000_0001);
    rdChk(dshs_pkg::ADDR_STATUS, 32'h0000_0112);
    wr(dshs_pkg::ADDR_CTRL, 32'h0000_0041);
    lowCount(40, 1'b1, n);
    chk(n, 8);
  endtask
  task automatic end_sim;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // A hang past the expected run of under a thousand cycles ends the run as failed.
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    $display("unexpected at %0t: timeout", $time);
    end_sim();
  end
  initial begin
    {resetn, avs_read, avs_write, avs_address} = 8'h00;
    avs_writedata = 32'h0000_0000;
    gpio_in = 4'h3;
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    tReset();
    tRxd();
    tTxd();
    tGpio();
    tCall();
    end_sim();
  end
endmodule
